/* File: dop_exec.sv */
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
module dop_exec
	import dop_pkg::*;
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	logic [ADDR_W-1:0] aw_addr_reg;
	logic aw_full_reg;
	logic [DATA_W-1:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic w_full_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic rvalid_reg;
	logic [1:0] rresp_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic do_write;
	logic [DATA_W-1:0] rd_word;
	logic [DATA_W-1:0] stat_word;

	logic [15:0] instr_reg;
	logic [15:0] src_reg;
	logic [15:0] dst_reg;
	logic [15:0] result_reg;
	logic [3:0] cc_reg;
	logic exec_reg;
	logic wrote_reg;
	logic group_reg;
	logic byte_reg;

	dop_op_e opk;
	logic is_b;
	logic dst_is_reg;
	logic [15:0] op_x;
	logic [15:0] op_y;
	logic op_cin;
	logic [16:0] sum17;
	logic [8:0] sum9;
	logic [15:0] arith_r;
	logic cout;
	logic [15:0] alu_r;
	logic sign_r;
	logic zero_r;
	logic ovf;
	logic [3:0] cc_next;
	logic write_en;
	logic [15:0] dest_word;

	assign s_axi_awready = !aw_full_reg && !bvalid_reg;
	assign s_axi_wready = !w_full_reg && !bvalid_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = rdata_reg;
	assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;

	// Address and data are held separately so they may arrive in either order.
	always_ff @(posedge clock) begin
		if (!nrst) begin
			aw_addr_reg <= 8'h00;
			aw_full_reg <= 1'b0;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
			w_full_reg <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr_reg <= s_axi_awaddr;
				aw_full_reg <= 1'b1;
			end else if (do_write) begin
				aw_full_reg <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
				w_full_reg <= 1'b1;
			end else if (do_write) begin
				w_full_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
		end else if (do_write) begin
			bvalid_reg <= 1'b1;
			bresp_reg <= dop_reg_hit(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	always_comb begin
		stat_word = 32'h00000000;
		stat_word[ST_WROTE] = wrote_reg;
		stat_word[ST_GROUP] = group_reg;
		stat_word[ST_BYTE] = byte_reg;
		stat_word[ST_BUSY] = exec_reg;
		stat_word[ST_SRC_LO +: 6] = instr_reg[SRC_HI:SRC_LO];
		stat_word[ST_DST_LO +: 6] = instr_reg[DSTF_HI:DSTF_LO];
		case (s_axi_araddr)
			ADDR_INSTR: rd_word = {16'h0000, instr_reg};
			ADDR_SRC: rd_word = {16'h0000, src_reg};
			ADDR_DST: rd_word = {16'h0000, dst_reg};
			ADDR_CC: rd_word = {28'h0000000, cc_reg};
			ADDR_RES: rd_word = {16'h0000, result_reg};
			ADDR_STAT: rd_word = stat_word;
			default: rd_word = 32'h00000000;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			rvalid_reg <= 1'b0;
			rresp_reg <= RESP_OKAY;
			rdata_reg <= 32'h00000000;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_reg <= 1'b1;
			rresp_reg <= dop_reg_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			rdata_reg <= rd_word;
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	// Operand and instruction words written by software.
	always_ff @(posedge clock) begin
		if (!nrst) begin
			instr_reg <= WORD_RESET;
			src_reg <= WORD_RESET;
			dst_reg <= WORD_RESET;
		end else if (do_write) begin
			case (aw_addr_reg)
				ADDR_INSTR: instr_reg <= 16'(dop_wmerge({16'h0000, instr_reg}, w_data_reg,
					w_strb_reg));
				ADDR_SRC: src_reg <= 16'(dop_wmerge({16'h0000, src_reg}, w_data_reg,
					w_strb_reg));
				ADDR_DST: dst_reg <= 16'(dop_wmerge({16'h0000, dst_reg}, w_data_reg,
					w_strb_reg));
				default: ;
			endcase
		end
	end

	// A write to the instruction word runs it on the next cycle.
	always_ff @(posedge clock) begin
		if (!nrst) begin
			exec_reg <= 1'b0;
		end else begin
			exec_reg <= do_write && (aw_addr_reg == ADDR_INSTR);
		end
	end

	assign opk = dop_decode(instr_reg[OPC_HI:OPC_LO]);
	assign is_b = dop_is_byte(instr_reg[OPC_HI:OPC_LO]);
	assign dst_is_reg = instr_reg[DMODE_HI:DMODE_LO] == MODE_REG;

	always_comb begin
		op_x = src_reg;
		op_y = dst_reg;
		op_cin = 1'b0;
		case (opk)
			OPK_SUB: begin
				op_x = dst_reg;
				op_y = ~src_reg;
				op_cin = 1'b1;
			end
			OPK_CMP: begin
				op_x = src_reg;
				op_y = ~dst_reg;
				op_cin = 1'b1;
			end
			default: ;
		endcase
		sum17 = {1'b0, op_x} + {1'b0, op_y} + {16'h0000, op_cin};
		sum9 = {1'b0, op_x[7:0]} + {1'b0, op_y[7:0]} + {8'h00, op_cin};
		arith_r = is_b ? {8'h00, sum9[7:0]} : sum17[15:0];
		cout = is_b ? sum9[8] : sum17[16];
		case (opk)
			OPK_MOV: alu_r = src_reg;
			OPK_BIT: alu_r = src_reg & dst_reg;
			OPK_BIC: alu_r = dst_reg & ~src_reg;
			OPK_BIS: alu_r = src_reg | dst_reg;
			OPK_CMP, OPK_ADD, OPK_SUB: alu_r = arith_r;
			default: alu_r = dst_reg;
		endcase
		sign_r = is_b ? alu_r[7] : alu_r[15];
		zero_r = is_b ? (alu_r[7:0] == 8'h00) : (alu_r == 16'h0000);
		// Inverting the second operand lets one test serve add, subtract and compare.
		ovf = ((is_b ? op_x[7] : op_x[15]) == (is_b ? op_y[7] : op_y[15])) &&
			(sign_r != (is_b ? op_x[7] : op_x[15]));
		cc_next = cc_reg;
		if (opk != OPK_NONE) begin
			cc_next[CC_N] = sign_r;
			cc_next[CC_Z] = zero_r;
			cc_next[CC_V] = 1'b0;
		end
		case (opk)
			OPK_ADD: begin
				cc_next[CC_V] = ovf;
				cc_next[CC_C] = cout;
			end
			OPK_SUB, OPK_CMP: begin
				cc_next[CC_V] = ovf;
				cc_next[CC_C] = !cout;
			end
			default: ;
		endcase
		write_en = (opk == OPK_MOV) || (opk == OPK_BIC) || (opk == OPK_BIS) ||
			(opk == OPK_ADD) || (opk == OPK_SUB);
		if (!is_b) begin
			dest_word = alu_r;
		end else if ((opk == OPK_MOV) && dst_is_reg) begin
			dest_word = {{8{alu_r[7]}}, alu_r[7:0]};
		end else begin
			dest_word = {dst_reg[15:8], alu_r[7:0]};
		end
	end

	// Condition flags: execution wins over a software write in the same cycle.
	always_ff @(posedge clock) begin
		if (!nrst) begin
			cc_reg <= CC_RESET;
		end else if (exec_reg) begin
			cc_reg <= cc_next;
		end else if (do_write && (aw_addr_reg == ADDR_CC)) begin
			cc_reg <= 4'(dop_wmerge({28'h0000000, cc_reg}, w_data_reg, w_strb_reg));
		end
	end

	// The result word always holds the destination's contents after the operation.
	always_ff @(posedge clock) begin
		if (!nrst) begin
			result_reg <= WORD_RESET;
			wrote_reg <= 1'b0;
			group_reg <= 1'b0;
			byte_reg <= 1'b0;
		end else if (exec_reg) begin
			result_reg <= write_en ? dest_word : dst_reg;
			wrote_reg <= write_en;
			group_reg <= opk != OPK_NONE;
			byte_reg <= is_b;
		end
	end

	chk_move_word: assert property (@(posedge clock) disable iff (!nrst)
		exec_reg && opk == OPK_MOV && !is_b |=> result_reg == $past(src_reg) && wrote_reg)
		else $error("word move result wrong");
	chk_move_flags: assert property (@(posedge clock) disable iff (!nrst)
		exec_reg && opk == OPK_MOV && !is_b |=> !cc_reg[CC_V] &&
		cc_reg[CC_C] == $past(cc_reg[CC_C]) && cc_reg[CC_N] == $past(src_reg[15]) &&
		cc_reg[CC_Z] == ($past(src_reg) == 16'h0000))
		else $error("move flags wrong");
	chk_byte_sext: assert property (@(posedge clock) disable iff (!nrst)
		exec_reg && opk == OPK_MOV && is_b && dst_is_reg |=>
		result_reg == {{8{$past(src_reg[7])}}, $past(src_reg[7:0])})
		else $error("byte move sign extension wrong");
	chk_byte_keep: assert property (@(posedge clock) disable iff (!nrst)
		exec_reg && is_b && !(opk == OPK_MOV && dst_is_reg) |=>
		result_reg[15:8] == $past(dst_reg[15:8]))
		else $error("byte op altered high byte");
	chk_cmp_flags: assert property (@(posedge clock) disable iff (!nrst)
		exec_reg && opk == OPK_CMP && !is_b |=> !wrote_reg &&
		result_reg == $past(dst_reg) && cc_reg[CC_Z] == ($past(src_reg) == $past(dst_reg)))
		else $error("compare wrote or zero flag wrong");
	chk_cmp_borrow: assert property (@(posedge clock) disable iff (!nrst)
		exec_reg && opk == OPK_CMP && !is_b |=> cc_reg[CC_C] == ($past(src_reg) < $past(dst_reg)))
		else $error("compare borrow wrong");
	chk_bit_test: assert property (@(posedge clock) disable iff (!nrst)
		exec_reg && opk == OPK_BIT && !is_b |=> !wrote_reg && !cc_reg[CC_V] &&
		cc_reg[CC_C] == $past(cc_reg[CC_C]) &&
		cc_reg[CC_Z] == (($past(src_reg) & $past(dst_reg)) == 16'h0000))
		else $error("bit test wrong");
	chk_bic_value: assert property (@(posedge clock) disable iff (!nrst)
		exec_reg && opk == OPK_BIC && !is_b |=> result_reg == ($past(dst_reg) & ~$past(src_reg)))
		else $error("bit clear result wrong");
	chk_bis_value: assert property (@(posedge clock) disable iff (!nrst)
		exec_reg && opk == OPK_BIS && !is_b |=> result_reg == ($past(src_reg) | $past(dst_reg)))
		else $error("bit set result wrong");
	chk_add_sum: assert property (@(posedge clock) disable iff (!nrst)
		exec_reg && opk == OPK_ADD |=> result_reg == 16'($past(src_reg) + $past(dst_reg)) &&
		cc_reg[CC_C] == (17'($past(src_reg)) + 17'($past(dst_reg)) > 17'h0FFFF))
		else $error("add sum or carry wrong");
	chk_sub_diff: assert property (@(posedge clock) disable iff (!nrst)
		exec_reg && opk == OPK_SUB |=> result_reg == 16'($past(dst_reg) - $past(src_reg)) &&
		cc_reg[CC_C] == ($past(dst_reg) < $past(src_reg)))
		else $error("subtract result or borrow wrong");
	chk_cmp_ovf: assert property (@(posedge clock) disable iff (!nrst)
		exec_reg && opk == OPK_CMP && !is_b |=>
		cc_reg[CC_V] == ($past(src_reg[15]) != $past(dst_reg[15]) &&
		$past(dst_reg[15]) == ((($past(src_reg) - $past(dst_reg)) & 16'h8000) != 16'h0000)))
		else $error("compare overflow wrong");
	chk_add_ovf: assert property (@(posedge clock) disable iff (!nrst)
		exec_reg && opk == OPK_ADD |=>
		cc_reg[CC_V] == ($past(src_reg[15]) == $past(dst_reg[15]) &&
		result_reg[15] != $past(src_reg[15])))
		else $error("add overflow wrong");
	chk_sub_ovf: assert property (@(posedge clock) disable iff (!nrst)
		exec_reg && opk == OPK_SUB |=>
		cc_reg[CC_V] == ($past(src_reg[15]) != $past(dst_reg[15]) &&
		result_reg[15] == $past(src_reg[15])) && cc_reg[CC_N] == result_reg[15] &&
		cc_reg[CC_Z] == (result_reg == 16'h0000))
		else $error("subtract flags wrong");
	chk_logic_flags: assert property (@(posedge clock) disable iff (!nrst)
		exec_reg && (opk == OPK_BIC || opk == OPK_BIS) && !is_b |=> !cc_reg[CC_V] &&
		cc_reg[CC_C] == $past(cc_reg[CC_C]) && cc_reg[CC_N] == result_reg[15] &&
		cc_reg[CC_Z] == (result_reg == 16'h0000))
		else $error("bit clear or set flags wrong");
	chk_byte_flags: assert property (@(posedge clock) disable iff (!nrst)
		exec_reg && is_b && write_en |=> cc_reg[CC_N] == result_reg[7] &&
		cc_reg[CC_Z] == (result_reg[7:0] == 8'h00))
		else $error("byte flags wrong");
	chk_idle_hold: assert property (@(posedge clock) disable iff (!nrst)
		exec_reg && opk == OPK_NONE |=> cc_reg == $past(cc_reg) && !group_reg && !wrote_reg)
		else $error("code outside group changed flags");

endmodule

/* File: dop_pkg.sv */
package dop_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	localparam logic [7:0] ADDR_INSTR = 8'h00;
	localparam logic [7:0] ADDR_SRC = 8'h04;
	localparam logic [7:0] ADDR_DST = 8'h08;
	localparam logic [7:0] ADDR_CC = 8'h0C;
	localparam logic [7:0] ADDR_RES = 8'h10;
	localparam logic [7:0] ADDR_STAT = 8'h14;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	localparam int CC_C = 0;
	localparam int CC_V = 1;
	localparam int CC_Z = 2;
	localparam int CC_N = 3;
	localparam logic [3:0] CC_RESET = 4'h0;
	localparam logic [15:0] WORD_RESET = 16'h0000;

	localparam int OPC_HI = 15;
	localparam int OPC_LO = 12;
	localparam int SRC_HI = 11;
	localparam int SRC_LO = 6;
	localparam int DSTF_HI = 5;
	localparam int DSTF_LO = 0;
	localparam int DMODE_HI = 5;
	localparam int DMODE_LO = 3;
	localparam logic [2:0] MODE_REG = 3'h0;

	localparam logic [2:0] CODE_MOV = 3'h1;
	localparam logic [2:0] CODE_CMP = 3'h2;
	localparam logic [2:0] CODE_BIT = 3'h3;
	localparam logic [2:0] CODE_BIC = 3'h4;
	localparam logic [2:0] CODE_BIS = 3'h5;
	localparam logic [2:0] CODE_ADD = 3'h6;

	localparam int ST_WROTE = 0;
	localparam int ST_GROUP = 1;
	localparam int ST_BYTE = 2;
	localparam int ST_BUSY = 3;
	localparam int ST_SRC_LO = 8;
	localparam int ST_DST_LO = 16;

	typedef enum logic [2:0] {
		OPK_NONE,
		OPK_MOV,
		OPK_CMP,
		OPK_BIT,
		OPK_BIC,
		OPK_BIS,
		OPK_ADD,
		OPK_SUB
	} dop_op_e;

	// The leading opcode bit picks the byte form for codes one to five, subtract for six.
	function automatic dop_op_e dop_decode(input logic [3:0] opc);
		dop_op_e k;
		k = OPK_NONE;
		case (opc[2:0])
			CODE_MOV: k = OPK_MOV;
			CODE_CMP: k = OPK_CMP;
			CODE_BIT: k = OPK_BIT;
			CODE_BIC: k = OPK_BIC;
			CODE_BIS: k = OPK_BIS;
			CODE_ADD: k = opc[3] ? OPK_SUB : OPK_ADD;
			default: k = OPK_NONE;
		endcase
		return k;
	endfunction

	function automatic logic dop_is_byte(input logic [3:0] opc);
		return opc[3] && (opc[2:0] >= CODE_MOV) && (opc[2:0] <= CODE_BIS);
	endfunction

	function automatic logic dop_reg_hit(input logic [7:0] addr);
		return (addr == ADDR_INSTR) || (addr == ADDR_SRC) || (addr == ADDR_DST) ||
			(addr == ADDR_CC) || (addr == ADDR_RES) || (addr == ADDR_STAT);
	endfunction

	function automatic logic [31:0] dop_wmerge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				m[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return m;
	endfunction

endpackage

/* File: tb_dop_exec.sv */
`timescale 1ns/10ps
module tb_dop_exec
	import dop_pkg::*;
;
	logic clock, nrst;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int bad_count = 0;
	int compares = 0;
	// Each entry: opcode, destination-in-memory flag, source, destination.
	logic [39:0] tv [21] = '{40'h1080001234, 40'h1100005555, 40'h9000801234, 40'h91007FAB34,
		40'h2080000001, 40'h2100010002, 40'hA000800001, 40'h30F0F00F0F, 40'hB112803480,
		40'h4100FFFFFF, 40'hC000FF12FF, 40'h5080000001, 40'hD012803401, 40'h607FFF0001,
		40'h61FFFF0001, 40'hE000018000, 40'hE100020001, 40'h0011112222, 40'h8011112222,
		40'h7133334444, 40'hF055556666};

	dop_exec i_dop_exec (.clock(clock), .nrst(nrst), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Called right after a rising edge; returns one edge after the response is taken.
	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
		int n;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge clock);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && s_axi_bready) break;
		end
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (n == 64) begin
			bad_count++;
			conclude();
		end
		@(posedge clock);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge clock);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && s_axi_rready) break;
		end
		v = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (n == 64) begin
			bad_count++;
			conclude();
		end
		@(posedge clock);
	endtask

	// Reference behaviour of one instruction on the stored operands and flags.
	function automatic void model(input logic [15:0] ins, input logic [15:0] s,
		input logic [15:0] d, input logic [3:0] cc, output logic [15:0] res,
		output logic [3:0] ccn, output logic [31:0] st);
		logic [2:0] k;
		logic by, grp, wrt, ci, co, xs, ys, rs;
		logic [15:0] x, y, r;
		logic [16:0] t;
		k = ins[14:12];
		grp = k >= 3'h1 && k <= 3'h6;
		by = ins[15] && grp && k != 3'h6;
		wrt = grp && k != 3'h2 && k != 3'h3;
		x = s;
		y = d;
		ci = 1'b0;
		if (k == 3'h2) begin
			y = ~d;
			ci = 1'b1;
		end
		if (k == 3'h6 && ins[15]) begin
			x = d;
			y = ~s;
			ci = 1'b1;
		end
		t = by ? {9'h000, x[7:0]} + {9'h000, y[7:0]} + 17'(ci) : {1'b0, x} + {1'b0, y} + 17'(ci);
		co = by ? t[8] : t[16];
		case (k)
			3'h1: r = s;
			3'h3: r = s & d;
			3'h4: r = d & ~s;
			3'h5: r = s | d;
			default: r = t[15:0];
		endcase
		xs = by ? x[7] : x[15];
		ys = by ? y[7] : y[15];
		rs = by ? r[7] : r[15];
		ccn = cc;
		if (grp) begin
			ccn[CC_N] = rs;
			ccn[CC_Z] = by ? r[7:0] == 8'h00 : r == 16'h0000;
			ccn[CC_V] = 1'b0;
			if (k == 3'h2 || k == 3'h6) begin
				ccn[CC_V] = xs == ys && rs != xs;
				ccn[CC_C] = co ^ ci;
			end
		end
		res = !wrt ? d : !by ? r : {(k == 3'h1 && ins[5:3] == MODE_REG) ? {8{r[7]}} : d[15:8],
			r[7:0]};
		st = {10'h000, ins[5:0], 2'h0, ins[11:6], 4'h0, 1'b0, by, grp, wrt};
	endfunction

	initial begin
		int i;
		logic [15:0] ins, s, d, res;
		logic [3:0] cc, ccn;
		logic [31:0] st, v;
		logic [1:0] rs;
		nrst = 1'b0;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_wdata = 32'h00000000;
		s_axi_wstrb = 4'hF;
		s_axi_bready = 1'b0;
		s_axi_rready = 1'b0;
		repeat (12) @(posedge clock);
		nrst <= 1'b1;
		@(posedge clock);
		for (i = 0; i < 6; i++) begin
			rd(8'(4 * i), v, rs);
			chk(v, 32'h00000000);
			chk({30'h0, rs}, {30'h0, RESP_OKAY});
		end
		$display("test reset values done");
		for (i = 0; i < 21; i++) begin
			s = tv[i][31:16];
			d = tv[i][15:0];
			cc = 4'(i * 7);
			ins = {tv[i][39:36], 6'(i * 5), tv[i][32] ? 6'h0B : 6'h03};
			model(ins, s, d, cc, res, ccn, st);
			wr(ADDR_SRC, {16'h0000, s}, rs);
			wr(ADDR_DST, {16'h0000, d}, rs);
			wr(ADDR_CC, {28'h0000000, cc}, rs);
			wr(ADDR_INSTR, {16'h0000, ins}, rs);
			chk({30'h0, rs}, {30'h0, RESP_OKAY});
			@(posedge clock);
			rd(ADDR_RES, v, rs);
			chk(v, {16'h0000, res});
			rd(ADDR_CC, v, rs);
			chk(v, {28'h0000000, ccn});
			rd(ADDR_STAT, v, rs);
			chk(v, st);
			rd(ADDR_SRC, v, rs);
			chk(v, {16'h0000, s});
		end
		$display("test instruction table done");
		wr(ADDR_RES, 32'h00005A5A, rs);
		chk({30'h0, rs}, {30'h0, RESP_OKAY});
		rd(ADDR_RES, v, rs);
		chk(v, {16'h0000, res});
		wr(8'h18, 32'h0000FFFF, rs);
		chk({30'h0, rs}, {30'h0, RESP_SLVERR});
		rd(8'hFC, v, rs);
		chk({30'h0, rs}, {30'h0, RESP_SLVERR});
		chk(v, 32'h00000000);
		$display("test bus errors done");
		conclude();
	end
endmodule
